// [design/ptw_pkg.sv]
// Constants and types shared by the timed trigger waveform generator.
// Notes on behaviour
// - Waveform select bits 22:20, reset 000, act once enabled and time reached; 111 reserved.
// - Code 000 drives output from idle high to low and holds it low.
// - Code 001 gives a rising edge at trigger time, output then stays high.
// - Code 010 gives one low pulse of pulse width, then stays high.
// - Code 011 gives one high pulse of pulse width, then stays low.
// - Code 100 periodic: low phase is pulse width, period is cycle width, counted.
// - Code 101 periodic: high phase is pulse width, period is cycle width, counted.
// - Code 110 shifts 16-bit pattern MSB first, looped, bit width each, counted.
// - Output toggle rate stays at or below 12.5 MHz; software programs widths accordingly.
// - Tail unit repeats the sequence iteration count plus one times; no tail repeats forever.
// - Cycle or bit width is a 32-bit field in 1 ns steps.
// - Bits 31:16 count cycles or bits; zero means endless output.
// - Serial bit pattern comes from bits 15:0 of the count register.
// - In cascade, next target time is current target plus the iteration time.
// - Pulse width is the 16-bit field at bits 15:0 in 8 ns steps.
// - Bits 23:16 extend the pulse width to 24 bits for long second pulses.
// - Indexed registers are per unit, selected by a 2-bit unit index first.
// - Pulse width register is second pulse width for unit 2, delay trim for unit 1.
// - Edge select one launches the output on the falling clock edge, else rising.
// - Immediate bit fires at once when the target time is already past.
// - Finished and fault flags are reported only while the notify bit is set.
// - Without a tail unit the loop never ends; soft clear stops it.
`default_nettype none
package ptw_pkg;
  // =====================================================================
  // Register map
  localparam logic [15:0] OFS_UNIT_INDEX = 16'h0520;
  localparam logic [15:0] OFS_UNIT_CMD = 16'h0524;
  localparam logic [15:0] OFS_SYS_TIME = 16'h0528;
  localparam logic [15:0] OFS_TARGET_TIME = 16'h0530;
  localparam logic [15:0] OFS_WAVE_CTRL = 16'h0534;
  localparam logic [15:0] OFS_CYCLE_WIDTH = 16'h053C;
  localparam logic [15:0] OFS_COUNT_PATTERN = 16'h0540;
  localparam logic [15:0] OFS_ITER_TIME = 16'h0544;
  localparam logic [15:0] OFS_PULSE_WIDTH = 16'h0548;
  // =====================================================================
  // Field positions
  localparam int CTRL_CASCADE = 31;
  localparam int CTRL_TAIL = 30;
  localparam int CTRL_NOW = 25;
  localparam int CTRL_NOTIFY = 24;
  localparam int CTRL_EDGE = 23;
  localparam int CTRL_PAT_LSB = 20;
  localparam int CMD_ENABLE = 0;
  localparam int CMD_SOFT_CLEAR = 1;
  localparam int CMD_FINISHED = 2;
  localparam int CMD_FAULT = 3;
  localparam int CMD_BUSY = 4;
  localparam logic [31:0] CTRL_WMASK = 32'hCFF0FFFF;
  localparam logic [31:0] PW_WMASK = 32'h00FFFFFF;
  // =====================================================================
  // Waveform codes
  localparam logic [2:0] PAT_NEG_EDGE = 3'h0;
  localparam logic [2:0] PAT_POS_EDGE = 3'h1;
  localparam logic [2:0] PAT_NEG_PULSE = 3'h2;
  localparam logic [2:0] PAT_POS_PULSE = 3'h3;
  localparam logic [2:0] PAT_NEG_PERIOD = 3'h4;
  localparam logic [2:0] PAT_POS_PERIOD = 3'h5;
  localparam logic [2:0] PAT_SERIAL = 3'h6;
  // =====================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PW_STEP_NS = 8;
  localparam int CW_STEP_NS = 1;
  localparam int MAX_TOGGLE_KHZ = 12500;
  localparam int PW_CYC_PER_STEP = PW_STEP_NS / CLK_PERIOD_NS;
  localparam int MIN_PERIOD_NS = 1000000 / MAX_TOGGLE_KHZ;
  localparam logic [31:0] MIN_PERIOD_CYC = 32'(MIN_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [31:0] TICK_NS = 32'(CLK_PERIOD_NS);
  localparam logic [1:0] UNIT_DELAY_TRIM = 2'h1;
  localparam logic [1:0] UNIT_SECOND_PULSE = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} ptw_state_t;
endpackage : ptw_pkg
`default_nettype wire

// [design/ptw_trigger_wave.sv]
// Timed trigger waveform generator with an APB register slave.
`default_nettype none
module ptw_trigger_wave (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic trig_out
);
  import ptw_pkg::*;

  // =====================================================================
  // State
  typedef struct packed {
    logic [1:0] unit_idx;
    logic [1:0] act_unit;
    logic enable;
    logic finished;
    logic fault;
    logic fresh;
    logic [31:0] ctrl;
    logic [31:0] target;
    logic [3:0][31:0] cyc_w;
    logic [3:0][31:0] cnt_pat;
    logic [3:0][31:0] iter_t;
    logic [3:0][23:0] pw;
    logic [31:0] sys_ns;
    ptw_state_t st;
    logic lvl;
    logic phase;
    logic [31:0] tmr;
    logic [15:0] left;
    logic [3:0] bit_i;
    logic [15:0] iter_left;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } ptw_regs_t;

  ptw_regs_t r_reg;
  ptw_regs_t r_next;
  logic neg_lvl_reg;

  // =====================================================================
  // Helpers
  function automatic logic [31:0] cw_cycles(input logic [31:0] w);
    logic [31:0] c;
    c = w * 32'(CW_STEP_NS) / 32'(CLK_PERIOD_NS);
    // Clamping holds the cycle or bit width at one toggle-ceiling period or more; pulse width and iteration time are not clamped.
    cw_cycles = (c < MIN_PERIOD_CYC) ? MIN_PERIOD_CYC : c;
  endfunction : cw_cycles

  function automatic logic [31:0] pw_cycles(input logic [23:0] w, input logic [1:0] u);
    logic [31:0] c;
    c = (u == UNIT_SECOND_PULSE) ? {8'h00, w} : {16'h0000, w[15:0]};
    c = c * 32'(PW_CYC_PER_STEP);
    pw_cycles = (c == 32'h0) ? 32'h1 : c;
  endfunction : pw_cycles

  function automatic logic idle_level(input logic [2:0] p);
    idle_level = !(p == PAT_POS_EDGE || p == PAT_POS_PULSE || p == PAT_POS_PERIOD);
  endfunction : idle_level

  logic [2:0] pat;
  logic [1:0] u;
  logic [31:0] pwc;
  logic [31:0] cwc;
  logic [15:0] bits;
  logic [31:0] comp;
  logic [31:0] diff;
  logic reached;
  logic late;
  logic start;
  logic fin;
  logic rearm;
  logic [31:0] tgt_sum;
  logic wr;

  always_comb begin
    pat = r_reg.ctrl[CTRL_PAT_LSB +: 3];
    u = r_reg.act_unit;
    pwc = pw_cycles(r_reg.pw[u], u);
    cwc = cw_cycles(r_reg.cyc_w[u]);
    bits = r_reg.cnt_pat[u][15:0];
    // Unit 1 uses the width field as a delay trim on its firing time.
    comp = (u == UNIT_DELAY_TRIM) ? {16'h0000, r_reg.pw[u][15:0]} * 32'(PW_STEP_NS) : 32'h0;
    diff = r_reg.sys_ns - r_reg.target - comp;
    reached = !diff[31];
    late = reached && (diff >= TICK_NS);
    tgt_sum = r_reg.target + r_reg.iter_t[u];
    wr = psel && penable && pwrite && r_reg.ready;
  end

  // =====================================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    start = 1'b0;
    fin = 1'b0;
    rearm = 1'b0;
    r_next.sys_ns = r_reg.sys_ns + TICK_NS;
    // The read word is latched in the setup cycle so prdata leaves a flop.
    r_next.ready = psel && !penable;
    r_next.slverr = 1'b0;
    r_next.rdata = 32'h0;
    if (psel && !penable) begin
      case (paddr)
        OFS_UNIT_INDEX: r_next.rdata = {30'h0, r_reg.unit_idx};
        OFS_UNIT_CMD: r_next.rdata = {27'h0, r_reg.st != ST_IDLE, r_reg.fault,
                                      r_reg.finished, 1'b0, r_reg.enable};
        OFS_SYS_TIME: r_next.rdata = r_reg.sys_ns;
        OFS_TARGET_TIME: r_next.rdata = r_reg.target;
        OFS_WAVE_CTRL: r_next.rdata = r_reg.ctrl;
        OFS_CYCLE_WIDTH: r_next.rdata = r_reg.cyc_w[r_reg.unit_idx];
        OFS_COUNT_PATTERN: r_next.rdata = r_reg.cnt_pat[r_reg.unit_idx];
        OFS_ITER_TIME: r_next.rdata = r_reg.iter_t[r_reg.unit_idx];
        OFS_PULSE_WIDTH: r_next.rdata = {8'h00, r_reg.pw[r_reg.unit_idx]};
        default: r_next.slverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        OFS_UNIT_INDEX: r_next.unit_idx = pwdata[1:0];
        OFS_UNIT_CMD: begin
          if (pwdata[CMD_FINISHED]) begin
            r_next.finished = 1'b0;
          end
          if (pwdata[CMD_FAULT]) begin
            r_next.fault = 1'b0;
          end
          r_next.enable = pwdata[CMD_ENABLE];
          if (pwdata[CMD_ENABLE] && !r_reg.enable) begin
            r_next.st = ST_ARMED;
            r_next.fresh = 1'b1;
            r_next.act_unit = r_reg.unit_idx;
            r_next.iter_left = r_reg.ctrl[15:0];
          end
        end
        OFS_TARGET_TIME: r_next.target = pwdata;
        OFS_WAVE_CTRL: r_next.ctrl = pwdata & CTRL_WMASK;
        OFS_CYCLE_WIDTH: r_next.cyc_w[r_reg.unit_idx] = pwdata;
        OFS_COUNT_PATTERN: r_next.cnt_pat[r_reg.unit_idx] = pwdata;
        OFS_ITER_TIME: r_next.iter_t[r_reg.unit_idx] = pwdata;
        OFS_PULSE_WIDTH: r_next.pw[r_reg.unit_idx] = pwdata[23:0] & PW_WMASK[23:0];
        default: r_next.slverr = 1'b0;
      endcase
    end

    case (r_reg.st)
      ST_IDLE: begin
        r_next.lvl = idle_level(pat);
      end
      ST_ARMED: begin
        if (reached) begin
          if (late && r_reg.fresh && !r_reg.ctrl[CTRL_NOW]) begin
            r_next.fault = r_next.fault || r_reg.ctrl[CTRL_NOTIFY];
            r_next.st = ST_DONE;
          end else begin
            start = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (r_reg.tmr != 32'h0) begin
          r_next.tmr = r_reg.tmr - 32'h1;
        end else begin
          case (pat)
            PAT_NEG_PULSE, PAT_POS_PULSE: begin
              r_next.lvl = !r_reg.lvl;
              fin = 1'b1;
            end
            PAT_NEG_PERIOD, PAT_POS_PERIOD: begin
              if (!r_reg.phase) begin
                r_next.lvl = !r_reg.lvl;
                r_next.phase = 1'b1;
                r_next.tmr = (cwc > pwc) ? cwc - pwc - 32'h1 : 32'h0;
              end else if (r_reg.left == 16'h1) begin
                fin = 1'b1;
              end else begin
                r_next.left = (r_reg.left == 16'h0) ? 16'h0 : r_reg.left - 16'h1;
                r_next.lvl = !r_reg.lvl;
                r_next.phase = 1'b0;
                r_next.tmr = pwc - 32'h1;
              end
            end
            PAT_SERIAL: begin
              if (r_reg.left == 16'h1) begin
                r_next.lvl = idle_level(pat);
                fin = 1'b1;
              end else begin
                r_next.left = (r_reg.left == 16'h0) ? 16'h0 : r_reg.left - 16'h1;
                r_next.lvl = bits[r_reg.bit_i];
                r_next.bit_i = r_reg.bit_i - 4'h1;
                r_next.tmr = cwc - 32'h1;
              end
            end
            default: fin = 1'b1;
          endcase
        end
      end
      ST_DONE: begin
        if (!r_reg.enable) begin
          r_next.st = ST_IDLE;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    if (start) begin
      r_next.fresh = 1'b0;
      r_next.st = ST_RUN;
      r_next.phase = 1'b0;
      r_next.left = r_reg.cnt_pat[u][31:16];
      r_next.tmr = pwc - 32'h1;
      r_next.lvl = !idle_level(pat);
      case (pat)
        PAT_NEG_EDGE: begin
          r_next.lvl = 1'b0;
          fin = 1'b1;
        end
        PAT_POS_EDGE: begin
          r_next.lvl = 1'b1;
          fin = 1'b1;
        end
        PAT_SERIAL: begin
          r_next.lvl = bits[15];
          r_next.bit_i = 4'hE;
          r_next.tmr = cwc - 32'h1;
        end
        PAT_NEG_PULSE, PAT_POS_PULSE, PAT_NEG_PERIOD, PAT_POS_PERIOD: begin
          r_next.bit_i = 4'hF;
        end
        default: begin
          r_next.lvl = idle_level(pat);
          r_next.fault = r_next.fault || r_reg.ctrl[CTRL_NOTIFY];
          r_next.st = ST_DONE;
        end
      endcase
    end

    if (fin) begin
      // Without a tail the chain repeats until software clears the unit.
      if (r_reg.ctrl[CTRL_CASCADE] && !(r_reg.ctrl[CTRL_TAIL] && r_reg.iter_left == 16'h0)) begin
        rearm = 1'b1;
        r_next.target = tgt_sum;
        r_next.iter_left = r_reg.iter_left - {15'h0, r_reg.ctrl[CTRL_TAIL]};
        r_next.st = ST_ARMED;
      end else begin
        // Building on the cleared copy lets a same-cycle set win over a software clear.
        r_next.finished = r_next.finished || r_reg.ctrl[CTRL_NOTIFY];
        r_next.st = ST_DONE;
      end
    end

    if (wr && paddr == OFS_UNIT_CMD && pwdata[CMD_SOFT_CLEAR]) begin
      r_next.st = ST_IDLE;
      r_next.enable = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.lvl <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // =====================================================================
  // Output launch
  // The falling-edge copy lags by half a cycle; the mux adds no glitch since
  // the select only changes under software control.
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      neg_lvl_reg <= 1'b1;
    end else begin
      neg_lvl_reg <= r_reg.lvl;
    end
  end

  assign trig_out = r_reg.ctrl[CTRL_EDGE] ? neg_lvl_reg : r_reg.lvl;
  assign prdata = r_reg.rdata;
  assign pready = r_reg.ready;
  assign pslverr = r_reg.slverr;

  // =====================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence low_for_two_s;
    !r_reg.lvl [*2];
  endsequence

  sequence high_for_two_s;
    r_reg.lvl [*2];
  endsequence

  sequence bit_hold_s;
    $stable(r_reg.lvl) [*8] ##1 $stable(r_reg.lvl);
  endsequence

  reserved_code_a: assert property (start && pat == 3'h7 |=> r_reg.st == ST_DONE)
    else $error("reserved waveform code started a sequence");
  neg_edge_hold_a: assert property (start && pat == PAT_NEG_EDGE && !r_reg.ctrl[CTRL_CASCADE]
    |=> low_for_two_s)
    else $error("falling edge output did not stay low");
  pos_edge_hold_a: assert property (start && pat == PAT_POS_EDGE && !r_reg.ctrl[CTRL_CASCADE]
    |=> high_for_two_s)
    else $error("rising edge output did not stay high");
  neg_pulse_len_a: assert property (start && pat == PAT_NEG_PULSE && pwc == 32'h3
    |=> low_for_two_s ##1 !r_reg.lvl ##1 r_reg.lvl)
    else $error("low pulse length wrong");
  pos_pulse_len_a: assert property (start && pat == PAT_POS_PULSE && pwc == 32'h4
    |=> high_for_two_s ##1 high_for_two_s ##1 !r_reg.lvl)
    else $error("high pulse length wrong");
  period_shape_a: assert property (start && pat == PAT_NEG_PERIOD && pwc == 32'h2
    && cwc == 32'hA && r_reg.cnt_pat[u][31:16] != 16'h1
    |=> low_for_two_s ##1 r_reg.lvl [*8] ##1 !r_reg.lvl)
    else $error("periodic low phase or period wrong");
  notify_gate_a: assert property (!r_reg.ctrl[CTRL_NOTIFY] && !r_reg.finished
    |=> !r_reg.finished)
    else $error("finished flag set while notify is off");
  cascade_step_a: assert property (rearm
    |=> r_reg.target == $past(r_reg.target) + $past(r_reg.iter_t[r_reg.act_unit]))
    else $error("cascade target not advanced by iteration time");
  serial_bit_hold_a: assert property (start && pat == PAT_SERIAL && cwc == 32'hA
    |=> ##1 bit_hold_s ##1 r_reg.lvl == bits[14])
    else $error("serial bit width or order wrong");
  soft_clear_idle_a: assert property (wr && paddr == OFS_UNIT_CMD && pwdata[CMD_SOFT_CLEAR]
    |=> r_reg.st == ST_IDLE && !r_reg.enable)
    else $error("soft clear did not return the unit to idle");
  late_refuse_a: assert property (r_reg.st == ST_ARMED && late && r_reg.fresh && !wr
    && !r_reg.ctrl[CTRL_NOW] |=> r_reg.st == ST_DONE && $stable(r_reg.lvl))
    else $error("late target fired instead of being refused");
endmodule : ptw_trigger_wave
`default_nettype wire

// [sim/ptw_trig_receiver.sv]
// Receiver model for the trigger output: counts edges and measures run lengths.
`default_nettype none
module ptw_trig_receiver (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic trig_out,
  output logic [15:0] falls,
  output logic [15:0] rises,
  output logic [15:0] low_len,
  output logic [15:0] high_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_reg;
  logic [15:0] low_run;
  logic [15:0] high_run;
  // Sampling at the rising edge only: a falling-edge launch still shows as whole cycles.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // The output idles high out of reset, so the edge detector starts high.
      prev_reg <= 1'b1;
      falls <= 16'h0000;
      rises <= 16'h0000;
      low_run <= 16'h0000;
      high_run <= 16'h0000;
      low_len <= 16'h0000;
      high_len <= 16'h0000;
    end else if (clr) begin
      prev_reg <= trig_out;
      falls <= 16'h0000;
      rises <= 16'h0000;
      low_run <= 16'h0000;
      high_run <= 16'h0000;
      low_len <= 16'h0000;
      high_len <= 16'h0000;
    end else begin
      prev_reg <= trig_out;
      if (prev_reg === 1'b1 && trig_out === 1'b0) begin
        falls <= falls + 16'h0001;
        high_len <= high_run;
      end
      if (prev_reg === 1'b0 && trig_out === 1'b1) begin
        rises <= rises + 16'h0001;
        low_len <= low_run;
      end
      low_run <= (trig_out === 1'b0) ? low_run + 16'h0001 : 16'h0000;
      high_run <= (trig_out === 1'b1) ? high_run + 16'h0001 : 16'h0000;
    end
  end
endmodule : ptw_trig_receiver
`default_nettype wire

// [sim/ptp_trigger_output_waveform_test.sv]
// Self-checking testbench for the timed trigger waveform generator.
`default_nettype none
module ptp_trigger_output_waveform_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ptw_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mon_clr = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, trig_out;
  logic [15:0] falls, rises, low_len, high_len;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  ptw_trigger_wave u_ptw_trigger_wave (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_out(trig_out));
  ptw_trig_receiver u_ptw_trig_receiver (.clk_sys(clk_sys), .rst(rst), .clr(mon_clr),
    .trig_out(trig_out), .falls(falls), .rises(rises), .low_len(low_len),
    .high_len(high_len));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // =====================================================================
  // Common tasks
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    check(q, exp);
  endtask : rd_chk
  // Soft clear, program unit 0, aim the target, enable, then poll a status flag.
  task automatic arm(input logic [31:0] ctrl, input logic [31:0] pw, input logic [31:0] cw,
                     input logic [31:0] cp, input logic [31:0] it, input logic [31:0] off,
                     input logic [31:0] mask);
    logic [31:0] q;
    logic e;
    int n;
    wr(OFS_UNIT_CMD, 32'h0000000E);
    wr(OFS_UNIT_INDEX, 32'h00000000);
    wr(OFS_PULSE_WIDTH, pw);
    wr(OFS_CYCLE_WIDTH, cw);
    wr(OFS_COUNT_PATTERN, cp);
    wr(OFS_ITER_TIME, it);
    wr(OFS_WAVE_CTRL, ctrl | 32'h01000000);
    apb(1'b0, OFS_SYS_TIME, 32'h00000000, q, e);
    wr(OFS_TARGET_TIME, q + off);
    mon_clr <= 1'b1;
    @(posedge clk_sys);
    mon_clr <= 1'b0;
    wr(OFS_UNIT_CMD, 32'h00000001);
    n = 0;
    do begin
      apb(1'b0, OFS_UNIT_CMD, 32'h00000000, q, e);
      n++;
    end while ((q & mask) == 32'h00000000 && n < 300);
    if (n >= 300) fails++;
  endtask : arm
  // =====================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd_chk(OFS_WAVE_CTRL, 32'h00000000);
    rd_chk(OFS_CYCLE_WIDTH, 32'h00000000);
    rd_chk(OFS_ITER_TIME, 32'h00000000);
    apb(1'b0, 16'h0600, 32'h00000000, q, e);
    check({31'h00000000, e}, 32'h00000001);
    check(q, 32'h00000000);
    wr(OFS_PULSE_WIDTH, 32'hFFFFFFFF);
    rd_chk(OFS_PULSE_WIDTH, 32'h00FFFFFF);
    wr(OFS_UNIT_INDEX, 32'h00000001);
    wr(OFS_CYCLE_WIDTH, 32'h00000123);
    rd_chk(OFS_CYCLE_WIDTH, 32'h00000123);
    wr(OFS_UNIT_INDEX, 32'h00000000);
    rd_chk(OFS_CYCLE_WIDTH, 32'h00000000);
    check({31'h00000000, trig_out}, 32'h00000001);
  endtask : t_regs
  task automatic t_edges();
    arm({9'h000, PAT_NEG_EDGE, 20'h00000}, 0, 0, 0, 0, 32'd400, 32'h4);
    check({falls, 15'h0000, trig_out}, 32'h00010000);
    arm({9'h000, PAT_POS_EDGE, 20'h00000}, 0, 0, 0, 0, 32'd400, 32'h4);
    check({rises, 15'h0000, trig_out}, 32'h00010001);
  endtask : t_edges
  task automatic t_pulses();
    arm({9'h000, PAT_NEG_PULSE, 20'h00000}, 32'd3, 0, 0, 0, 32'd400, 32'h4);
    check({falls, low_len}, 32'h00010003);
    arm({9'h000, PAT_POS_PULSE, 20'h00000}, 32'd4, 0, 0, 0, 32'd400, 32'h4);
    check({rises, high_len}, 32'h00010004);
  endtask : t_pulses
  task automatic t_periodic();
    arm({9'h000, PAT_NEG_PERIOD, 20'h00000}, 32'd2, 32'd80, 32'h00030000, 0, 32'd400, 32'h4);
    check({falls, low_len}, 32'h00030002);
    check({16'h0000, high_len}, 32'h00000008);
    arm({9'h000, PAT_POS_PERIOD, 20'h00000}, 32'd2, 32'd160, 32'h00030000, 0, 32'd400, 32'h4);
    check({rises, high_len}, 32'h00030002);
  endtask : t_periodic
  task automatic t_serial();
    // Ten bits of F0FF give a 40-cycle low run only when shifted out MSB first.
    arm({9'h000, PAT_SERIAL, 20'h00000}, 0, 32'd80, 32'h000AF0FF, 0, 32'd400, 32'h4);
    check({falls, low_len}, 32'h00010028);
  endtask : t_serial
  task automatic t_refused();
    arm({9'h000, 3'h7, 20'h00000}, 0, 0, 0, 0, 32'd400, 32'h8);
    check({falls, rises}, 32'h00000000);
    arm({9'h000, PAT_NEG_EDGE, 20'h00000}, 0, 0, 0, 0, 32'hFFFFFCE0, 32'h8);
    check({falls, 16'h0000}, 32'h00000000);
    arm(32'h02000000, 0, 0, 0, 0, 32'hFFFFFCE0, 32'h4);
    check({falls, 15'h0000, trig_out}, 32'h00010000);
  endtask : t_refused
  // A falling-edge launch shows the new level only after the next falling clock edge.
  task automatic t_launch();
    arm({9'h001, PAT_NEG_EDGE, 20'h00000}, 0, 0, 0, 0, 32'd400, 32'h4);
    check({falls, 15'h0000, trig_out}, 32'h00010000);
    wr(OFS_UNIT_CMD, 32'h00000002);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h00000000, trig_out}, 32'h00000000);
    @(posedge clk_sys);
    check({31'h00000000, trig_out}, 32'h00000001);
    wr(OFS_UNIT_CMD, 32'h0000000E);
    wr(OFS_WAVE_CTRL, 32'h02000000);
    wr(OFS_UNIT_CMD, 32'h00000001);
    rd_chk(OFS_UNIT_CMD, 32'h00000011);
  endtask : t_launch
  task automatic t_cascade();
    arm({9'h180, PAT_NEG_PULSE, 20'h00002}, 32'd1, 0, 0, 32'd800, 32'd400, 32'h4);
    repeat (350) @(posedge clk_sys);
    check({falls, low_len}, 32'h00030001);
  endtask : t_cascade
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_edges();
    t_pulses();
    t_periodic();
    t_serial();
    t_refused();
    t_launch();
    t_cascade();
    tally_and_finish();
  end
endmodule : ptp_trigger_output_waveform_test
`default_nettype wire
